// File: shared/rwc_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef RWC_REGS_SVH
`define RWC_REGS_SVH

// ==========================================================
// Register offsets (byte addresses)
`define RWC_ADDR_W        12
`define RWC_OFS_CAUSE     12'h000
`define RWC_OFS_WDCTL     12'h004

// ==========================================================
// Field positions
`define RWC_CAUSE_POR     0
`define RWC_CAUSE_PIN     1
`define RWC_CAUSE_BOD     2
`define RWC_CAUSE_WDOG    3
`define RWC_WD_PER_LO     0
`define RWC_WD_RE         3
`define RWC_WD_CE         4
`define RWC_WD_PER_HI     5
`define RWC_WD_IE         6
`define RWC_WD_IFLAG      7

// ==========================================================
// Reset and special values
`define RWC_CAUSE_RST     4'h1
`define RWC_PER_RST       4'h0
`define RWC_PER_LAST      4'h9
`define RWC_BOD_OFF       3'h7

// ==========================================================
// Timing
`define RWC_CLK_HZ        20000000
`define RWC_CLK_NS        50
`define RWC_OSC_HZ        128000
`define RWC_OSC_DIV       (`RWC_CLK_HZ / `RWC_OSC_HZ)
`define RWC_WD_BASE       2048
`define RWC_CE_CYC        4
`define RWC_BOD_MIN_NS    2000
`define RWC_BOD_MIN_CYC   ((`RWC_BOD_MIN_NS + `RWC_CLK_NS - 1) / `RWC_CLK_NS)
`define RWC_PIN_MIN_NS    2500
`define RWC_PIN_MIN_CYC   ((`RWC_PIN_MIN_NS + `RWC_CLK_NS - 1) / `RWC_CLK_NS)

`endif

// File: shared/rwc_pkg.sv
// Types shared by the reset and watchdog controller
package rwc_pkg;

  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_HOLD  = 2'b01,
    ST_WDP   = 2'b10,
    ST_DELAY = 2'b11
  } rwc_state_e;

  typedef struct packed {
    logic [7:0]  div;
    logic [20:0] cnt;
    logic        expire;
  } rwc_wdog_s;

  typedef struct packed {
    logic [7:0] pin_cnt;
    logic [7:0] bod_cnt;
    logic       por_act;
    logic       pin_act;
    logic       bod_act;
  } rwc_src_s;

  typedef struct packed {
    rwc_state_e  state;
    logic [15:0] dly;
    logic [15:0] startup;
    logic        level2;
    logic        pin_dis;
    logic        bod_en;
    logic [3:0]  cause;
    logic        iflag;
    logic        ie;
    logic        ce;
    logic [1:0]  ce_cnt;
    logic        re;
    logic [3:0]  per;
    logic        wd_exp;
    logic        sys_rst_n;
    logic        irq;
    logic        bandgap;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } rwc_top_s;

endpackage : rwc_pkg

// File: shared/rwc_if.sv
// Interfaces between the controller and its two helper modules
`timescale 1ns/100ps

interface rwc_wdog_if;
  logic       run;
  logic       restart;
  logic [3:0] period;
  logic       expire;
  modport ctl  (output run, output restart, output period, input expire);
  modport wdog (input run, input restart, input period, output expire);
endinterface : rwc_wdog_if

interface rwc_src_if;
  logic pin_dis;
  logic bod_en;
  logic sys_rel;
  logic por_act;
  logic pin_act;
  logic bod_act;
  modport ctl (output pin_dis, output bod_en, output sys_rel,
               input por_act, input pin_act, input bod_act);
  modport src (input pin_dis, input bod_en, input sys_rel,
               output por_act, output pin_act, output bod_act);
endinterface : rwc_src_if

// File: core/rwc_wdog.sv
// Watchdog oscillator tick divider and time-out counter
`timescale 1ns/100ps
`include "rwc_regs.svh"

module rwc_wdog
  import rwc_pkg::*;
#(
  parameter int unsigned OSC_DIV = `RWC_OSC_DIV,
  parameter int unsigned WD_BASE = `RWC_WD_BASE
) (
  input wire logic   pclk,
  input wire logic   presetn,
  rwc_wdog_if.wdog   wd
);

  rwc_wdog_s q;
  rwc_wdog_s d;
  logic      tick;

  // Reserved codes fall back to the longest valid period
  function automatic logic [20:0] wd_limit(input logic [3:0] code);
    logic [3:0] eff;
    eff = (code > `RWC_PER_LAST) ? `RWC_PER_LAST : code;
    return (21'(WD_BASE) << eff) - 21'h000001;
  endfunction : wd_limit

  // ==========================================================
  // Next state
  always_comb begin
    d        = q;
    d.expire = 1'b0;
    tick     = (q.div == 8'(OSC_DIV - 1));
    d.div    = tick ? 8'h00 : q.div + 8'h01;
    if (!wd.run || wd.restart) begin
      d.cnt = 21'h000000;
    end else if (tick) begin
      if (q.cnt >= wd_limit(wd.period)) begin
        d.cnt    = 21'h000000;
        d.expire = 1'b1;
      end else begin
        d.cnt = q.cnt + 21'h000001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign wd.expire = q.expire;

endmodule : rwc_wdog

// File: core/rwc_rstsrc.sv
// Reset source qualification and asynchronous port reset
`timescale 1ns/100ps
`include "rwc_regs.svh"

module rwc_rstsrc
  import rwc_pkg::*;
#(
  parameter int unsigned PIN_MIN = `RWC_PIN_MIN_CYC,
  parameter int unsigned BOD_MIN = `RWC_BOD_MIN_CYC
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic power_good,
  input  wire logic reset_pin_n,
  input  wire logic brownout_low,
  rwc_src_if.src    sr,
  output logic      io_rst_n
);

  localparam rwc_src_s SRC_RST = '{pin_cnt: 8'h00, bod_cnt: 8'h00,
                                   por_act: 1'b1, pin_act: 1'b0,
                                   bod_act: 1'b0};

  rwc_src_s q;
  rwc_src_s d;
  logic     io_q;
  logic     async_n;

  // Supply drop and an enabled reset pin pull the port reset with no clock needed
  assign async_n = presetn & power_good
                 & (reset_pin_n | sr.pin_dis);

  // ==========================================================
  // Qualification
  always_comb begin
    d         = q;
    d.por_act = ~power_good;
    if (reset_pin_n || sr.pin_dis) begin
      d.pin_cnt = 8'h00;
    end else if (q.pin_cnt != 8'(PIN_MIN)) begin
      d.pin_cnt = q.pin_cnt + 8'h01;
    end
    d.pin_act = (d.pin_cnt == 8'(PIN_MIN));
    // Dips shorter than the minimum never reach the controller
    if (!brownout_low || !sr.bod_en) begin
      d.bod_cnt = 8'h00;
    end else if (q.bod_cnt != 8'(BOD_MIN)) begin
      d.bod_cnt = q.bod_cnt + 8'h01;
    end
    d.bod_act = (d.bod_cnt == 8'(BOD_MIN));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= SRC_RST;
    end else begin
      q <= d;
    end
  end

  // Released when the stretched internal reset ends, or on the next clock after a pin pulse too short to qualify
  always_ff @(posedge pclk or negedge async_n) begin
    if (!async_n) begin
      io_q <= 1'b0;
    end else begin
      io_q <= sr.sys_rel;
    end
  end

  assign io_rst_n   = io_q;
  assign sr.por_act = q.por_act;
  assign sr.pin_act = q.pin_act;
  assign sr.bod_act = q.bod_act;

endmodule : rwc_rstsrc

// File: core/rwc_top.sv
// Reset controller with watchdog, cause flags and APB register access
//
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/100ps
`include "rwc_regs.svh"

// Contract
// - During reset I/O registers take initial values; release starts code.
// - Port reset asserts at once on any source, without a clock; here brown-out and watchdog reach it one clock after internal reset.
// - After all sources end, internal reset is stretched by a delay count.
// - Four causes: power-on, external pin, watchdog, enabled brown-out.
// - Supply rise starts the delay; supply drop resets immediately.
// - Pin held low long enough resets; its rising edge starts the delay.
// - Reset pin disable fuse makes the pin ignored.
// - Enabled brown-out low resets at once; recovery starts the delay.
// - Brown-out counts only if it lasts past the minimum duration.
// - Watchdog reset is a one-cycle pulse; delay starts after it.
// - Bandgap on if brown-out fuse, comparator select or ADC enable.
// - Watchdog counts ticks of a 128 kHz oscillator rate.
// - Watchdog counter clears on restart, when disabled, and on reset.
// - Ten selectable periods; expiry in reset mode resets the chip.
// - Expiry may raise an interrupt flag instead of a reset.
// - Always-on fuse picks level 1 or level 2 watchdog safety.
// - Level 1: writing reset-enable one enables with no sequence.
// - Level 2: watchdog stays enabled and reset-enable reads one.
// - Cause register bits 7..4 read zero.
// - Watchdog flag set by watchdog reset, cleared by power-on or zero.
// - Brown-out, pin, power-on flags; power-on flag cleared by zero only.
// - Change enable clears itself four cycles after being written.
// - Reset-enable forced one while the watchdog cause flag is set.
// - Codes pick 2048 to 1048576 cycles; reserved codes fall back.
module rwc_top
  import rwc_pkg::*;
#(
  parameter int unsigned OSC_DIV = `RWC_OSC_DIV,
  parameter int unsigned WD_BASE = `RWC_WD_BASE,
  parameter int unsigned PIN_MIN = `RWC_PIN_MIN_CYC,
  parameter int unsigned BOD_MIN = `RWC_BOD_MIN_CYC
) (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`RWC_ADDR_W-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   power_good,
  input  wire logic                   reset_pin_n,
  input  wire logic                   brownout_low,
  input  wire logic [2:0]             brownout_level_fuse,
  input  wire logic                   reset_pin_disable_fuse,
  input  wire logic                   wdog_always_on_fuse,
  input  wire logic [15:0]            startup_cycles,
  input  wire logic                   comparator_bandgap_select,
  input  wire logic                   adc_enable,
  input  wire logic                   wdog_restart_instruction,
  output logic                        sys_rst_n,
  output logic                        io_rst_n,
  output logic                        wdog_irq,
  output logic                        bandgap_en
);

  localparam rwc_top_s TOP_RST = '{
    state:     ST_HOLD,
    dly:       16'h0000,
    startup:   16'h0000,
    level2:    1'b0,
    pin_dis:   1'b0,
    bod_en:    1'b0,
    cause:     `RWC_CAUSE_RST,
    iflag:     1'b0,
    ie:        1'b0,
    ce:        1'b0,
    ce_cnt:    2'h0,
    re:        1'b0,
    per:       `RWC_PER_RST,
    wd_exp:    1'b0,
    sys_rst_n: 1'b0,
    irq:       1'b0,
    bandgap:   1'b0,
    pready:    1'b0,
    pslverr:   1'b0,
    prdata:    32'h00000000
  };

  rwc_top_s   q;
  rwc_top_s   d;
  logic       hard;
  logic       wd_rst;
  logic       set_if;
  logic       acc;
  logic       wr_cause;
  logic       wr_ctl;
  logic       second_step;
  logic       hit;
  logic [3:0] w_per;
  logic [31:0] rd;

  rwc_wdog_if wd ();
  rwc_src_if  sr ();

  // ==========================================================
  // Helpers
  rwc_wdog #(
    .OSC_DIV (OSC_DIV),
    .WD_BASE (WD_BASE)
  ) u_wdog (
    .pclk    (pclk),
    .presetn (presetn),
    .wd      (wd)
  );

  rwc_rstsrc #(
    .PIN_MIN (PIN_MIN),
    .BOD_MIN (BOD_MIN)
  ) u_src (
    .pclk         (pclk),
    .presetn      (presetn),
    .power_good   (power_good),
    .reset_pin_n  (reset_pin_n),
    .brownout_low (brownout_low),
    .sr           (sr),
    .io_rst_n     (io_rst_n)
  );

  assign wd.run     = (q.state == ST_RUN) && (q.re || q.ie);
  assign wd.restart = wdog_restart_instruction;
  assign wd.period  = q.per;
  assign sr.pin_dis = q.pin_dis;
  assign sr.bod_en  = q.bod_en;
  assign sr.sys_rel = q.sys_rst_n;

  // ==========================================================
  // Next state
  always_comb begin
    d      = q;
    hard   = sr.por_act | sr.pin_act | sr.bod_act;
    wd_rst = 1'b0;
    set_if = 1'b0;
    acc    = psel & penable & q.pready;
    wr_cause    = acc && pwrite && (paddr == `RWC_OFS_CAUSE);
    wr_ctl      = acc && pwrite && (paddr == `RWC_OFS_WDCTL);
    second_step = wr_ctl && q.ce && !pwdata[`RWC_WD_CE];
    w_per = {pwdata[`RWC_WD_PER_HI],
             pwdata[`RWC_WD_PER_LO+2:`RWC_WD_PER_LO]};

    // Expiry action by mode; level 2 always resets
    d.wd_exp = wd.expire;
    if (q.wd_exp && q.state == ST_RUN) begin
      if (q.level2 || (q.re && (!q.ie || q.iflag))) begin
        wd_rst = 1'b1;
      end
      if (!q.level2 && q.ie && !(q.re && q.iflag)) begin
        set_if = 1'b1;
      end
    end

    // Stretching state machine
    case (q.state)
      ST_RUN: begin
        if (hard) begin
          d.state = ST_HOLD;
        end else if (wd_rst) begin
          d.state = ST_WDP;
        end
      end
      ST_HOLD: begin
        if (!hard) begin
          d.state = ST_DELAY;
          d.dly   = q.startup;
        end
      end
      ST_WDP: begin
        // Delay begins once the one-cycle pulse ends
        d.state = hard ? ST_HOLD : ST_DELAY;
        d.dly   = q.startup;
      end
      ST_DELAY: begin
        if (hard) begin
          d.state = ST_HOLD;
        end else if (q.dly == 16'h0000) begin
          d.state = ST_RUN;
        end else begin
          d.dly = q.dly - 16'h0001;
        end
      end
      default: begin
        d.state = ST_HOLD;
      end
    endcase
    d.sys_rst_n = (d.state == ST_RUN);

    // Configuration is caught only while reset is held
    if (q.state != ST_RUN) begin
      d.level2  = wdog_always_on_fuse;
      d.pin_dis = reset_pin_disable_fuse;
      d.bod_en  = (brownout_level_fuse != `RWC_BOD_OFF);
      d.startup = startup_cycles;
    end

    // Cause flags: clear by zero write, then hardware sets win
    if (wr_cause) begin
      d.cause = q.cause & pwdata[3:0];
    end
    if (sr.por_act) begin
      d.cause = `RWC_CAUSE_RST;
    end else begin
      if (sr.pin_act) begin
        d.cause[`RWC_CAUSE_PIN] = 1'b1;
      end
      if (sr.bod_act) begin
        d.cause[`RWC_CAUSE_BOD] = 1'b1;
      end
      if (wd_rst) begin
        d.cause[`RWC_CAUSE_WDOG] = 1'b1;
      end
    end

    // Watchdog control
    if (q.state != ST_RUN) begin
      d.ie     = 1'b0;
      d.iflag  = 1'b0;
      d.ce     = 1'b0;
      d.ce_cnt = 2'h0;
      d.re     = 1'b0;
      d.per    = `RWC_PER_RST;
    end else begin
      if (q.ce) begin
        if (q.ce_cnt == 2'h0) begin
          d.ce = 1'b0;
        end else begin
          d.ce_cnt = q.ce_cnt - 2'h1;
        end
      end
      if (wr_ctl) begin
        d.ie = pwdata[`RWC_WD_IE];
        if (pwdata[`RWC_WD_IFLAG]) begin
          d.iflag = 1'b0;
        end
        if (!q.level2) begin
          d.per = w_per;
          if (pwdata[`RWC_WD_RE]) begin
            d.re = 1'b1;
          end else if (second_step) begin
            d.re = 1'b0;
          end
        end else if (second_step) begin
          d.per = w_per;
        end
        if (pwdata[`RWC_WD_CE] && pwdata[`RWC_WD_RE]) begin
          d.ce     = 1'b1;
          d.ce_cnt = 2'(`RWC_CE_CYC - 1);
        end else if (!pwdata[`RWC_WD_CE]) begin
          d.ce = 1'b0;
        end
      end
      if (set_if) begin
        d.iflag = 1'b1;
      end
    end
    // Level 2 and a pending watchdog cause both pin the enable high
    d.re = d.re | d.level2 | d.cause[`RWC_CAUSE_WDOG];

    d.irq     = d.iflag & d.ie;
    d.bandgap = d.bod_en | comparator_bandgap_select
              | adc_enable;

    // APB slave: one wait state, registered answer
    hit = (paddr == `RWC_OFS_CAUSE) || (paddr == `RWC_OFS_WDCTL);
    case (paddr)
      `RWC_OFS_CAUSE: rd = {28'h0000000, q.cause};
      `RWC_OFS_WDCTL: rd = {24'h000000, q.iflag, q.ie, q.per[3], q.ce,
                            q.re, q.per[2:0]};
      default:        rd = 32'h00000000;
    endcase
    d.pready = psel & penable & ~q.pready;
    if (psel && penable && !q.pready) begin
      d.prdata  = rd;
      d.pslverr = !hit;
    end else begin
      d.pslverr = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= TOP_RST;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // Outputs
  assign prdata     = q.prdata;
  assign pready     = q.pready;
  assign pslverr    = q.pslverr;
  assign sys_rst_n  = q.sys_rst_n;
  assign wdog_irq   = q.irq;
  assign bandgap_en = q.bandgap;

endmodule : rwc_top

// File: verification/rwc_far.sv
// Far-side model: supply monitors and external reset pin
`timescale 1ns/100ps

// ==========================================================
// Supply and pin model
module rwc_far (
  input  wire logic pclk,
  output logic      power_good,
  output logic      reset_pin_n,
  output logic      brownout_low
);
  // Supply comes up a few cycles in, so every run opens with a power-on
  initial begin
    power_good   = 1'b0;
    reset_pin_n  = 1'b1;
    brownout_low = 1'b0;
    repeat (3) @(posedge pclk);
    power_good <= 1'b1;
  end

  // Pin has a pull-up, so a release always returns it high
  task automatic pulse(input int src, input int len);
    @(posedge pclk);
    case (src)
      0: power_good <= 1'b0;
      1: reset_pin_n <= 1'b0;
      default: brownout_low <= 1'b1;
    endcase
    repeat (len) @(posedge pclk);
    power_good   <= 1'b1;
    reset_pin_n  <= 1'b1;
    brownout_low <= 1'b0;
  endtask : pulse
endmodule : rwc_far

// File: verification/rwc_properties.sv
// Port-level checks for the reset and watchdog controller
`timescale 1ns/100ps

// ==========================================================
// Checker
module rwc_properties #(
  parameter int unsigned BOD_MIN = 3
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        power_good,
  input wire logic        reset_pin_n,
  input wire logic        brownout_low,
  input wire logic [2:0]  brownout_level_fuse,
  input wire logic        reset_pin_disable_fuse,
  input wire logic        wdog_always_on_fuse,
  input wire logic [15:0] startup_cycles,
  input wire logic        comparator_bandgap_select,
  input wire logic        adc_enable,
  input wire logic        sys_rst_n,
  input wire logic        io_rst_n,
  input wire logic        wdog_irq,
  input wire logic        bandgap_en
);
  logic [16:0] low_q;
  logic [7:0]  bod_q;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Run lengths of internal reset low and of the brown-out input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_q <= 17'h0;
      bod_q <= 8'h0;
    end else begin
      low_q <= sys_rst_n ? 17'h0 : low_q + 17'h1;
      bod_q <= brownout_low ? bod_q + 8'h1 : 8'h0;
    end
  end

  por_io_low_a: assert property (!power_good |-> !io_rst_n)
    else $error("port reset missed a supply drop");
  pin_io_low_a: assert property (!reset_pin_n
    && !reset_pin_disable_fuse |-> !io_rst_n)
    else $error("port reset missed the pin");
  por_sys_low_a: assert property (!power_good |-> ##[0:2] !sys_rst_n)
    else $error("internal reset late on supply drop");
  stretch_a: assert property ($rose(sys_rst_n)
    |-> low_q > {1'b0, startup_cycles}) else $error("reset too short");
  bod_fire_a: assert property (brownout_level_fuse != 3'h7
    && bod_q == BOD_MIN + 1 |-> ##[0:4] !sys_rst_n)
    else $error("brown-out did not reset");
  bod_filter_a: assert property (sys_rst_n && $fell(brownout_low)
    && bod_q == 8'h1 |-> sys_rst_n [*4]) else $error("short dip reset");
  pin_ignored_a: assert property (reset_pin_disable_fuse
    && $fell(reset_pin_n) && sys_rst_n |-> sys_rst_n [*8])
    else $error("disabled pin caused reset");
  bandgap_on_a: assert property (adc_enable
    || comparator_bandgap_select |=> bandgap_en)
    else $error("bandgap not enabled");
  bandgap_off_a: assert property (brownout_level_fuse == 3'h7
    && !adc_enable && !comparator_bandgap_select && sys_rst_n
    |=> !bandgap_en) else $error("bandgap left on");
  apb_wait_a: assert property (psel && $rose(penable)
    |-> !pready ##1 pready) else $error("wrong wait states");
  apb_err_a: assert property (pready
    |-> pslverr == (paddr != 12'h000 && paddr != 12'h004))
    else $error("wrong error response");
  cause_rsvd_a: assert property (pready && !pwrite && paddr == 12'h000
    |-> prdata[31:4] == 28'h0) else $error("reserved cause bits set");
  lvl2_re_a: assert property (pready && !pwrite && paddr == 12'h004
    && wdog_always_on_fuse |-> prdata[3]) else $error("level 2 re clear");
  irq_mode_a: assert property ($rose(wdog_irq) |-> sys_rst_n [*4])
    else $error("interrupt mode reset the chip");

  cover property ($fell(sys_rst_n) && power_good && reset_pin_n);
  cover property ($rose(wdog_irq));
  cover property (pready && pslverr);
endmodule : rwc_properties

bind rwc_top rwc_properties #(.BOD_MIN(BOD_MIN)) rwc_properties_inst (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
  .pslverr, .power_good, .reset_pin_n, .brownout_low, .brownout_level_fuse,
  .reset_pin_disable_fuse, .wdog_always_on_fuse, .startup_cycles,
  .comparator_bandgap_select, .adc_enable, .sys_rst_n, .io_rst_n,
  .wdog_irq, .bandgap_en);

// File: verification/tb.sv
// Self-checking bench for the reset and watchdog controller
`timescale 1ns/100ps
`define CHK(g, e) begin \
  n_checks++; \
  if ((g) !== (e)) begin \
    failures++; \
    $display("unexpected at %0t got %h expected %h", $time, (g), (e)); \
  end \
end

// ==========================================================
// Bench
module tb;
  localparam int unsigned OSC_DIV = 4;
  localparam int unsigned WD_BASE = 16;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic        pready, pslverr, err;
  logic        power_good, reset_pin_n, brownout_low;
  logic [2:0]  brownout_level_fuse;
  logic        reset_pin_disable_fuse, wdog_always_on_fuse;
  logic [15:0] startup_cycles;
  logic        comparator_bandgap_select, adc_enable;
  logic        wdog_restart_instruction;
  logic        sys_rst_n, io_rst_n, wdog_irq, bandgap_en;
  int          failures = 0, n_checks = 0, cycles = 0, waited, per;
  int          seed = 32'hE48DD173;

  rwc_top #(.OSC_DIV(OSC_DIV), .WD_BASE(WD_BASE), .PIN_MIN(3), .BOD_MIN(3))
    rwc_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .power_good, .reset_pin_n,
    .brownout_low, .brownout_level_fuse, .reset_pin_disable_fuse,
    .wdog_always_on_fuse, .startup_cycles, .comparator_bandgap_select,
    .adc_enable, .wdog_restart_instruction, .sys_rst_n, .io_rst_n,
    .wdog_irq, .bandgap_en);
  rwc_far rwc_far_inst (.pclk, .power_good, .reset_pin_n, .brownout_low);

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // A hang ends the run through the same report
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      complete_run();
    end
  end

  always @(posedge pclk) begin
    adc_enable                <= 1'($random(seed));
    comparator_bandgap_select <= 1'($random(seed));
  end

  // ==========================================================
  // Helpers
  function automatic int wd_cycles(input int p);
    return (WD_BASE << p) * OSC_DIV;
  endfunction : wd_cycles

  // Tick phase of the free-running divider blurs expiry by a few cycles
  function automatic logic wd_near(input int w, input int p);
    return (w >= wd_cycles(p) - 6) && (w <= wd_cycles(p) + 10);
  endfunction : wd_near

  // Leaves the request up so a following call is a back-to-back setup
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n == 16) failures++;
    rdata = prdata;
    err   = pslverr;
  endtask : apb

  task automatic idle();
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : idle

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    idle();
  endtask : wr

  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
    idle();
  endtask : rd

  task automatic wait_for(input logic irq, input logic v, input int lim);
    waited = 0;
    while ((irq ? wdog_irq : sys_rst_n) !== v && waited < lim) begin
      @(posedge pclk);
      waited++;
    end
    if (waited == lim) failures++;
  endtask : wait_for

  task automatic complete_run();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run

  // ==========================================================
  // Scenarios
  initial begin
    {presetn, psel, penable, pwrite, wdog_restart_instruction} = 5'h0;
    {paddr, pwdata} = 44'h0;
    brownout_level_fuse    = 3'h4;
    reset_pin_disable_fuse = 1'b0;
    wdog_always_on_fuse    = 1'b0;
    startup_cycles         = 16'($unsigned($random(seed)) % 16);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    wait_for(1'b0, 1'b1, 200);
    rd(12'h000);
    `CHK(rdata, 32'h1)
    rd(12'h004);
    `CHK(rdata, 32'h0)
    wr(12'h000, 32'h0);
    wr(12'h000, 32'hFFFFFFFF);
    rd(12'h000);
    `CHK(rdata, 32'h0)
    rd(12'h008);
    `CHK(err, 1'b1)
    for (int k = 1; k < 3; k++) begin
      rwc_far_inst.pulse(k, 1);
      repeat (6) @(posedge pclk);
      `CHK(sys_rst_n, 1'b1)
      rwc_far_inst.pulse(k, 8);
      `CHK(sys_rst_n, 1'b0)
      wait_for(1'b0, 1'b1, 200);
      rd(12'h000);
      `CHK(rdata[3:0], 4'h1 << k)
      if (k == 1) wr(12'h000, 32'h0);
    end
    rwc_far_inst.pulse(0, 4);
    wait_for(1'b0, 1'b1, 200);
    rd(12'h000);
    `CHK(rdata[3:0], 4'h1)
    wr(12'h000, 32'h0);
    per = $unsigned($random(seed)) % 3;
    wr(12'h004, 32'h8 | 32'(per));
    wait_for(1'b0, 1'b0, 2000);
    `CHK(wd_near(waited, per), 1'b1)
    wait_for(1'b0, 1'b1, 200);
    rd(12'h000);
    `CHK(rdata[3:0], 4'h8)
    rd(12'h004);
    `CHK(rdata[3], 1'b1)
    wr(12'h000, 32'h0);
    apb(1'b1, 12'h004, 32'h18);
    apb(1'b1, 12'h004, 32'h0);
    idle();
    rd(12'h004);
    `CHK(rdata[4:3], 2'b00)
    wr(12'h004, 32'h8);
    repeat (5) begin
      repeat (40) @(posedge pclk);
      wdog_restart_instruction <= 1'b1;
      @(posedge pclk);
      wdog_restart_instruction <= 1'b0;
    end
    rd(12'h000);
    `CHK(rdata[3:0], 4'h0)
    apb(1'b1, 12'h004, 32'h18);
    idle();
    repeat (6) @(posedge pclk);
    wr(12'h004, 32'h0);
    rd(12'h004);
    `CHK(rdata[4:3], 2'b01)
    apb(1'b1, 12'h004, 32'h18);
    apb(1'b1, 12'h004, 32'h0);
    idle();
    wr(12'h004, 32'h40);
    wait_for(1'b1, 1'b1, 400);
    `CHK(sys_rst_n, 1'b1)
    rd(12'h004);
    `CHK(rdata[7], 1'b1)
    wr(12'h004, 32'hC0);
    rd(12'h004);
    `CHK(rdata[7], 1'b0)
    wr(12'h004, 32'h48);
    wait_for(1'b1, 1'b1, 400);
    `CHK(sys_rst_n, 1'b1)
    wait_for(1'b0, 1'b0, 400);
    `CHK(wd_near(waited, 0), 1'b1)
    presetn                <= 1'b0;
    wdog_always_on_fuse    <= 1'b1;
    reset_pin_disable_fuse <= 1'b1;
    brownout_level_fuse    <= 3'h7;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    wait_for(1'b0, 1'b1, 200);
    rd(12'h004);
    `CHK(rdata[3], 1'b1)
    rwc_far_inst.pulse(1, 8);
    rwc_far_inst.pulse(2, 8);
    `CHK(sys_rst_n, 1'b1)
    wr(12'h004, 32'h1);
    rd(12'h004);
    `CHK(rdata[3:0], 4'h8)
    apb(1'b1, 12'h004, 32'h18);
    apb(1'b1, 12'h004, 32'h1);
    idle();
    rd(12'h004);
    `CHK(rdata[3:0], 4'h9)
    apb(1'b1, 12'h004, 32'h18);
    apb(1'b1, 12'h004, 32'h27);
    idle();
    wdog_restart_instruction <= 1'b1;
    @(posedge pclk);
    wdog_restart_instruction <= 1'b0;
    wait_for(1'b0, 1'b0, 33000);
    `CHK(wd_near(waited, 9), 1'b1)
    complete_run();
  end
endmodule : tb
